// ===== pwt_pkg.sv
package pwt_pkg;
  // special function register addresses
  localparam logic [7:0] SVC_ADDR    = 8'hA6;
  localparam logic [7:0] PRG_ADDR    = 8'hA7;
  // unlock and restart sequence bytes
  localparam logic [7:0] UNLOCK_1ST  = 8'h1E;
  localparam logic [7:0] UNLOCK_2ND  = 8'hE1;
  // timeout chain widths
  localparam int         PRE_W       = 14;
  localparam int         STG_W       = 7;
  localparam int         SEL_W       = 3;
  localparam int         CHAIN_W     = PRE_W + STG_W;
  localparam int         SEL_LSB     = 0;
  // oscillator periods per machine cycle, undoubled
  localparam logic [3:0] MC_OSC      = 4'h6;
  // reset pulse length in oscillator periods
  localparam logic [6:0] RSTP_OSC    = 7'h60;
  localparam logic [2:0] PRG_RESET   = 3'h0;

  typedef enum logic [2:0] {
    WD_OFF  = 3'b001,
    WD_RUN  = 3'b010,
    WD_FIRE = 3'b100
  } pwt_wd_e;

  typedef enum logic [1:0] {
    SQ_IDLE  = 2'b01,
    SQ_ARMED = 2'b10
  } pwt_seq_e;
endpackage : pwt_pkg

// ===== pwt_watchdog.sv
`timescale 1ns/100ps
module pwt_watchdog (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // special function register port
  input  wire logic [7:0] sfrAddr,
  input  wire logic [7:0] sfrWrData,
  input  wire logic       sfrWr,
  input  wire logic       sfrRd,
  output logic      [7:0] sfrRdData,
  input  wire logic       instrDone,
  // clocking and power state
  input  wire logic       oscTick,
  input  wire logic       coreClockDoubleMode,
  input  wire logic       watchdogClockDoubleSelect,
  input  wire logic       powerDown,
  input  wire logic       extIntLevel,
  // chip reset request
  output logic            chipResetOut
);
  import pwt_pkg::*;

  pwt_wd_e                 wdState_r, wdState_nxt;
  pwt_seq_e                seq_r, seq_nxt;
  logic [PRE_W-1:0]        prescale_r, prescale_nxt;
  logic [STG_W-1:0]        stage_r, stage_nxt;
  logic [SEL_W-1:0]        periodSel_r, periodSel_nxt;
  logic [3:0]              divCnt_r, divCnt_nxt;
  logic [6:0]              pulseCnt_r, pulseCnt_nxt;
  logic                    wakeHold_r, wakeHold_nxt;
  logic                    chipResetOut_r, chipResetOut_nxt;
  logic [7:0]              rdData_r, rdData_nxt;
  logic                    svcWr, prgWr, seqDone, countOk, countTick;
  logic                    atLimit;
  logic [3:0]              divTerm;
  logic [STG_W-1:0]        stageMask;

  //////////////////////////////////////////////////////////////////////////
  assign svcWr = sfrWr && (sfrAddr == SVC_ADDR);
  assign prgWr = sfrWr && (sfrAddr == PRG_ADDR);
  assign seqDone = (seq_r == SQ_ARMED) && svcWr
                   && (sfrWrData == UNLOCK_2ND);

  assign countOk = (wdState_r == WD_RUN) && !powerDown && !wakeHold_r;
  // machine cycle length
  // doubling dropped mid-cycle with the count above 5 stretches that one cycle past the wrap
  assign divTerm = (watchdogClockDoubleSelect ^ coreClockDoubleMode)
                   ? 4'((MC_OSC << 1) - 4'h1) : 4'(MC_OSC - 4'h1);
  assign countTick = countOk && oscTick && (divCnt_r == divTerm);
  assign stageMask = STG_W'((8'h01 << periodSel_r) - 8'h01);
  assign atLimit = (&prescale_r) && ((stage_r & stageMask) == stageMask);

  //////////////////////////////////////////////////////////////////////////
  // sequence detector
  always_comb begin
    seq_nxt = seq_r;
    case (seq_r)
      SQ_IDLE: begin
        if (svcWr && sfrWrData == UNLOCK_1ST) begin
          seq_nxt = SQ_ARMED;
        end
      end
      SQ_ARMED: begin
        if (svcWr && sfrWrData == UNLOCK_1ST) begin
          seq_nxt = SQ_ARMED;
        end else if (sfrWr || instrDone) begin
          seq_nxt = SQ_IDLE;
        end
      end
      default: seq_nxt = SQ_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    wdState_nxt      = wdState_r;
    prescale_nxt     = prescale_r;
    stage_nxt        = stage_r;
    divCnt_nxt       = divCnt_r;
    pulseCnt_nxt     = pulseCnt_r;
    periodSel_nxt    = periodSel_r;
    // hold after interrupt wake-up until the line goes high
    // level test: a line still low after wake keeps the chain parked
    wakeHold_nxt     = wakeHold_r;
    if (powerDown && !extIntLevel) begin
      wakeHold_nxt = 1'b1;
    end else if (extIntLevel) begin
      wakeHold_nxt = 1'b0;
    end
    case (wdState_r)
      WD_OFF: begin
        if (prgWr) begin
          periodSel_nxt = sfrWrData[SEL_LSB +: SEL_W];
        end
        if (seqDone) begin
          wdState_nxt  = WD_RUN;
          prescale_nxt = '0;
          stage_nxt    = '0;
          divCnt_nxt   = '0;
        end
      end
      WD_RUN: begin
        if (countOk && oscTick) begin
          divCnt_nxt = (divCnt_r == divTerm) ? 4'h0 : divCnt_r + 4'h1;
        end
        if (seqDone) begin
          prescale_nxt = '0;
          stage_nxt    = '0;
          divCnt_nxt   = '0;
        end else if (countTick && atLimit) begin
          wdState_nxt  = WD_FIRE;
          pulseCnt_nxt = '0;
        end else if (countTick) begin
          prescale_nxt = prescale_r + 1'b1;
          if (&prescale_r) begin
            stage_nxt = stage_r + 1'b1;
          end
        end
      end
      WD_FIRE: begin
        if (oscTick) begin
          if (pulseCnt_r == RSTP_OSC - 7'h01) begin
            wdState_nxt = WD_OFF;
          end else begin
            pulseCnt_nxt = pulseCnt_r + 7'h01;
          end
        end
      end
      default: wdState_nxt = WD_OFF;
    endcase
    chipResetOut_nxt = (wdState_nxt == WD_FIRE);
  end

  //////////////////////////////////////////////////////////////////////////
  // read: select field, or enable flag on the service address
  always_comb begin
    rdData_nxt = rdData_r;
    if (sfrRd) begin
      if (sfrAddr == PRG_ADDR) begin
        rdData_nxt = {5'h00, periodSel_r};
      end else if (sfrAddr == SVC_ADDR) begin
        rdData_nxt = {7'h00, wdState_r != WD_OFF};
      end else begin
        rdData_nxt = 8'h00;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // hardware reset clears everything
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wdState_r      <= WD_OFF;
      seq_r          <= SQ_IDLE;
      prescale_r     <= '0;
      stage_r        <= '0;
      periodSel_r    <= PRG_RESET;
      divCnt_r       <= 4'h0;
      pulseCnt_r     <= 7'h00;
      wakeHold_r     <= 1'b0;
      chipResetOut_r <= 1'b0;
      rdData_r       <= 8'h00;
    end else begin
      wdState_r      <= wdState_nxt;
      seq_r          <= seq_nxt;
      prescale_r     <= prescale_nxt;
      stage_r        <= stage_nxt;
      periodSel_r    <= periodSel_nxt;
      divCnt_r       <= divCnt_nxt;
      pulseCnt_r     <= pulseCnt_nxt;
      wakeHold_r     <= wakeHold_nxt;
      chipResetOut_r <= chipResetOut_nxt;
      rdData_r       <= rdData_nxt;
    end
  end

  assign sfrRdData    = rdData_r;
  assign chipResetOut = chipResetOut_r;

  //////////////////////////////////////////////////////////////////////////
  // checks against an independently formed chain limit
  logic [CHAIN_W:0] fullMask;
  assign fullMask = (CHAIN_W+1)'((23'h1 << (PRE_W + periodSel_r)) - 23'h1);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  AST_OFF_AT_START: assert property (
    $past(reset) |-> wdState_r == WD_OFF && !chipResetOut)
    else $error("watchdog not disabled after reset");
  AST_ENABLE_SEQ: assert property (
    $rose(wdState_r == WD_RUN) |-> $past(seq_r == SQ_ARMED && svcWr))
    else $error("enable without unlock sequence");
  AST_CARRY: assert property (
    countTick && !seqDone && !atLimit && (&prescale_r)
    |=> prescale_r == '0 && stage_r == $past(stage_r) + 1'b1)
    else $error("prescaler carry lost");
  AST_ADVANCE: assert property (
    countTick && !seqDone && !atLimit
    |=> prescale_r == $past(prescale_r) + 1'b1)
    else $error("chain did not advance");
  AST_NO_DISABLE: assert property (
    wdState_r == WD_RUN |=> wdState_r != WD_OFF)
    else $error("watchdog disabled while running");
  AST_FIRE: assert property (
    wdState_r == WD_RUN && countTick && atLimit && !seqDone
    |=> chipResetOut && wdState_r == WD_FIRE)
    else $error("overflow did not reset chip");
  AST_PULSE_END: assert property (
    chipResetOut && oscTick && pulseCnt_r == RSTP_OSC - 7'h01
    |=> !chipResetOut && wdState_r == WD_OFF)
    else $error("reset pulse length wrong");
  AST_PULSE_HOLD: assert property (
    chipResetOut && !(oscTick && pulseCnt_r == RSTP_OSC - 7'h01)
    |=> chipResetOut)
    else $error("reset pulse ended early");
  AST_PERIOD_LOCK: assert property (
    wdState_r != WD_OFF |=> $stable(periodSel_r))
    else $error("period changed while enabled");
  AST_SEL_FIELD: assert property (
    prgWr && wdState_r == WD_OFF |=> periodSel_r == $past(sfrWrData[2:0]))
    else $error("select field not stored");
  AST_LIMIT: assert property (
    atLimit |-> ({stage_r, prescale_r} & fullMask[CHAIN_W-1:0])
                == fullMask[CHAIN_W-1:0])
    else $error("overflow limit wrong");
  AST_DIVIDE: assert property (
    countTick |-> divCnt_r == ((watchdogClockDoubleSelect
      ^ coreClockDoubleMode) ? 4'hB : 4'h5))
    else $error("machine cycle divide wrong");
  AST_PD_HOLD: assert property (
    powerDown && wdState_r == WD_RUN && !seqDone
    |=> $stable(prescale_r) && $stable(stage_r) && !chipResetOut)
    else $error("counter moved in power-down");
  AST_WAKE_HOLD: assert property (
    wakeHold_r && !seqDone
    |=> $stable(prescale_r) && $stable(stage_r))
    else $error("counting while wake line low");
  AST_RESTART: assert property (
    wdState_r == WD_RUN && seqDone |=> prescale_r == '0 && stage_r == '0)
    else $error("restart did not clear chain");
  AST_ABORT: assert property (
    seq_r == SQ_ARMED && instrDone && !svcWr |=> seq_r == SQ_IDLE)
    else $error("sequence not aborted");
  AST_SEQ_ARM: assert property (
    svcWr && sfrWrData == UNLOCK_1ST |=> seq_r == SQ_ARMED)
    else $error("first unlock byte not armed");
  AST_ENABLE_CLEAR: assert property (
    wdState_r == WD_OFF && seqDone
    |=> wdState_r == WD_RUN && prescale_r == '0 && stage_r == '0)
    else $error("enable did not start from zero");
  AST_OFF_STILL: assert property (
    wdState_r == WD_OFF && !seqDone
    |=> $stable(prescale_r) && $stable(stage_r))
    else $error("chain moved while disabled");
  AST_OFF_NO_RST: assert property (
    wdState_r == WD_OFF |=> !chipResetOut)
    else $error("reset pulse while disabled");
  AST_PULSE_START: assert property (
    $rose(chipResetOut) |-> pulseCnt_r == '0)
    else $error("pulse count not cleared");
  AST_WAKE_SET: assert property (
    powerDown && !extIntLevel |=> wakeHold_r)
    else $error("wake hold not armed");
  AST_RD_PRG: assert property (
    sfrRd && sfrAddr == PRG_ADDR
    |=> sfrRdData == {5'h00, $past(periodSel_r)})
    else $error("period read wrong");

  COV_ENABLE: cover property ($rose(wdState_r == WD_RUN));
  COV_RESTART: cover property (wdState_r == WD_RUN && seqDone);
  COV_OVERFLOW: cover property ($rose(chipResetOut));
  COV_WAKE: cover property ($fell(wakeHold_r) && wdState_r == WD_RUN);
  COV_PULSE_DONE: cover property ($fell(chipResetOut));
endmodule : pwt_watchdog

// ===== test_pwt_watchdog.sv
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin testsRun++; if ((got) !== (exp)) begin \
  errorCnt++; $display("unexpected %s expected %0h seen %0h", nm, exp, got); \
  end end

module test_pwt_watchdog;
  import pwt_pkg::*;

  localparam int LIMIT = 100000;
  logic       core_clk;
  logic       reset                     = 1'b1;
  logic [7:0] sfrAddr                   = 8'h00;
  logic [7:0] sfrWrData                 = 8'h00;
  logic       sfrWr                     = 1'b0;
  logic       sfrRd                     = 1'b0;
  logic       instrDone                 = 1'b0;
  logic       oscTick                   = 1'b0;
  logic       coreClockDoubleMode       = 1'b0;
  logic       watchdogClockDoubleSelect = 1'b0;
  logic       powerDown                 = 1'b0;
  logic       extIntLevel               = 1'b1;
  logic [7:0] sfrRdData;
  logic       chipResetOut;
  int         errorCnt                  = 0;
  int         testsRun                  = 0;
  int         cycles                    = 0;
  int         n;
  int         m;

  pwt_watchdog pwt_watchdog_inst (
    .core_clk                  (core_clk),
    .reset                     (reset),
    .sfrAddr                   (sfrAddr),
    .sfrWrData                 (sfrWrData),
    .sfrWr                     (sfrWr),
    .sfrRd                     (sfrRd),
    .sfrRdData                 (sfrRdData),
    .instrDone                 (instrDone),
    .oscTick                   (oscTick),
    .coreClockDoubleMode       (coreClockDoubleMode),
    .watchdogClockDoubleSelect (watchdogClockDoubleSelect),
    .powerDown                 (powerDown),
    .extIntLevel               (extIntLevel),
    .chipResetOut              (chipResetOut)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic results;
    $display("mismatches %0d, comparisons %0d", errorCnt, testsRun);
    if (errorCnt == 0 && testsRun > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // hang guard, sized above the single full timeout run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errorCnt++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobes stay up so back-to-back writes share no lowering edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfrWr     <= 1'b1;
    sfrAddr   <= a;
    sfrWrData <= d;
    instrDone <= 1'b1;
  endtask : wr

  task automatic idle(input int k);
    repeat (k) begin
      @(posedge core_clk);
      sfrWr     <= 1'b0;
      sfrRd     <= 1'b0;
      instrDone <= 1'b0;
    end
  endtask : idle

  task automatic ins;
    @(posedge core_clk);
    sfrWr     <= 1'b0;
    instrDone <= 1'b1;
  endtask : ins

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e,
                       input string nm);
    @(posedge core_clk);
    sfrWr     <= 1'b0;
    instrDone <= 1'b0;
    sfrRd     <= 1'b1;
    sfrAddr   <= a;
    @(posedge core_clk);
    sfrRd     <= 1'b0;
    #1;
    `CHK(nm, e, sfrRdData)
  endtask : rdchk

  task automatic unlock;
    wr(SVC_ADDR, UNLOCK_1ST);
    wr(SVC_ADDR, UNLOCK_2ND);
    idle(1);
  endtask : unlock

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    rdchk(SVC_ADDR, 8'h00, "enable after reset");
    rdchk(PRG_ADDR, 8'h00, "select after reset");
    rdchk(8'h55, 8'h00, "unmapped read");
    wr(PRG_ADDR, 8'hFD);
    idle(1);
    rdchk(PRG_ADDR, 8'h05, "select field");
    wr(PRG_ADDR, 8'h00);
    // lone instruction and foreign write both break the pair
    wr(SVC_ADDR, UNLOCK_1ST);
    ins();
    wr(SVC_ADDR, UNLOCK_2ND);
    idle(1);
    rdchk(SVC_ADDR, 8'h00, "abort by instruction");
    wr(SVC_ADDR, UNLOCK_1ST);
    wr(PRG_ADDR, 8'h00);
    wr(SVC_ADDR, UNLOCK_2ND);
    idle(1);
    rdchk(SVC_ADDR, 8'h00, "abort by write");
    unlock();
    rdchk(SVC_ADDR, 8'h01, "enabled");
    wr(PRG_ADDR, 8'h07);
    idle(1);
    rdchk(PRG_ADDR, 8'h00, "select locked");
    wr(SVC_ADDR, 8'h00);
    idle(1);
    rdchk(SVC_ADDR, 8'h01, "no soft disable");
    // doubling xor one first: twelve ticks per machine cycle
    @(posedge core_clk);
    oscTick                   <= 1'b1;
    watchdogClockDoubleSelect <= 1'b1;
    repeat (100) @(posedge core_clk);
    unlock();
    repeat (100) @(posedge core_clk);
    unlock();
    unlock();
    // xor back to zero, six ticks per cycle for the timeout run
    @(posedge core_clk);
    oscTick             <= 1'b0;
    coreClockDoubleMode <= 1'b1;
    powerDown           <= 1'b1;
    extIntLevel         <= 1'b0;
    repeat (50) @(posedge core_clk);
    #1;
    `CHK("reset in power-down", 1'b0, chipResetOut)
    @(posedge core_clk);
    powerDown <= 1'b0;
    oscTick   <= 1'b1;
    repeat (200) @(posedge core_clk);
    #1;
    `CHK("reset in wake hold", 1'b0, chipResetOut)
    @(posedge core_clk);
    extIntLevel <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (chipResetOut !== 1'b1 && n < 98400);
    // wide low bound absorbs the few ticks before power-down
    `CHK("timeout window", 1'b1, (n >= 16383*6-8 && n <= 16384*6+4))
    m = 0;
    do begin
      @(posedge core_clk);
      #1;
      m++;
    end while (chipResetOut === 1'b1 && m < 200);
    `CHK("pulse length", 1'b1, (m >= 96 && m <= 98))
    rdchk(SVC_ADDR, 8'h00, "disabled after overflow");
    unlock();
    @(posedge core_clk);
    powerDown <= 1'b1;
    oscTick   <= 1'b0;
    reset     <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset     <= 1'b0;
    powerDown <= 1'b0;
    rdchk(SVC_ADDR, 8'h00, "disabled after pd reset");
    results();
  end
endmodule : test_pwt_watchdog
